// [rtl/sequencer_output_config_decode.sv]
// Functional notes
// - output 1 code decodes drive and polarity
// - code 100 selects tracking on outputs 1-4
// - code 101 selects charge pump, outputs 1-6
// - output 2 from config_a bits 5:3
// - output 3 from config_a 7:6, config_b 0
// - output 4 from config_b bits 3:1
// - output 5 from config_b 6:4, no tracking
// - output 6 from config_b 7, config_c 1:0
// - output 7 two-bit field config_c 3:2
// - output 8 two-bit field config_c 5:4
// - output 9 two-bit field config_c 7:6
module sequencer_output_config_decode (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // register port
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  input  wire logic       cfg_wr,
  input  wire logic       cfg_rd,
  output logic      [7:0] cfg_rdata,
  output logic            cfg_rvalid,
  // sequencer requests, one per output
  input  wire logic [8:0] assert_req,
  // output pins
  output logic      [8:0] pin_out,
  output logic      [8:0] pin_oe,
  // analog drive selects
  output logic      [3:0] track_en,
  output logic      [5:0] pump_en,
  // reserved code indication
  output logic      [8:0] reserved_code
);

  localparam int N  = seq_out_pkg::NUM_OUTPUTS;
  localparam int NW = seq_out_pkg::NUM_WIDE_OUTPUTS;
  localparam int NT = seq_out_pkg::NUM_TRACK_OUTPUTS;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [8:0] pin_out;
    logic [8:0] pin_oe;
    logic [3:0] track_en;
    logic [5:0] pump_en;
    logic [8:0] reserved_code;
    logic [7:0] rdata;
    logic       rvalid;
  } state_t;

  state_t state;
  state_t next_state;

  logic [7:0] config_a;
  logic [7:0] config_b;
  logic [7:0] config_c;

  logic [2:0] code [N];
  logic [N-1:0] drive_level;
  logic [N-1:0] drive_oe;
  logic [N-1:0] track_sel;
  logic [N-1:0] pump_sel;
  logic [N-1:0] reserved_hit;

  // ****************************************************************
  // configuration storage
  // ****************************************************************
  output_config_regs u_regs (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .cfg_addr  (cfg_addr),
    .cfg_wdata (cfg_wdata),
    .cfg_wr    (cfg_wr),
    .config_a  (config_a),
    .config_b  (config_b),
    .config_c  (config_c)
  );

  // ****************************************************************
  // field extraction
  // ****************************************************************
  always_comb begin
    code[0] = config_a[seq_out_pkg::OUT1_LSB +: 3];
    code[1] = config_a[seq_out_pkg::OUT2_LSB +: 3];
    code[2] = {config_b[seq_out_pkg::OUT3_HI_BIT],
               config_a[seq_out_pkg::OUT3_LO_LSB +: 2]};
    code[3] = config_b[seq_out_pkg::OUT4_LSB +: 3];
    code[4] = config_b[seq_out_pkg::OUT5_LSB +: 3];
    code[5] = {config_c[seq_out_pkg::OUT6_HI_LSB +: 2],
               config_b[seq_out_pkg::OUT6_LO_BIT]};
    // two-bit fields: top bit held zero, so only drive codes occur
    code[6] = {1'b0, config_c[seq_out_pkg::OUT7_LSB +: 2]};
    code[7] = {1'b0, config_c[seq_out_pkg::OUT8_LSB +: 2]};
    code[8] = {1'b0, config_c[seq_out_pkg::OUT9_LSB +: 2]};
  end

  // ****************************************************************
  // per-output decode
  // ****************************************************************
  for (genvar i = 0; i < N; i++) begin : g_out
    output_drive_decode u_dec (
      .code         (code[i]),
      .has_track    (i < NT ? 1'b1 : 1'b0),
      .has_pump     (i < NW ? 1'b1 : 1'b0),
      .assert_req   (assert_req[i]),
      .drive_level  (drive_level[i]),
      .drive_oe     (drive_oe[i]),
      .track_sel    (track_sel[i]),
      .pump_sel     (pump_sel[i]),
      .reserved_hit (reserved_hit[i])
    );
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_state               = state;
    next_state.pin_out       = drive_level & drive_oe;
    next_state.pin_oe        = drive_oe;
    next_state.track_en      = track_sel[NT-1:0];
    next_state.pump_en       = pump_sel[NW-1:0];
    next_state.reserved_code = reserved_hit;
    next_state.rvalid        = cfg_rd;
    if (cfg_rd) begin
      unique case (cfg_addr)
        seq_out_pkg::OUTPUT_CONFIG_A_OFFSET: next_state.rdata = config_a;
        seq_out_pkg::OUTPUT_CONFIG_B_OFFSET: next_state.rdata = config_b;
        seq_out_pkg::OUTPUT_CONFIG_C_OFFSET: next_state.rdata = config_c;
        seq_out_pkg::OUTPUT_STATUS_OFFSET: begin
          next_state.rdata = {|state.pump_en, |state.track_en,
                              state.reserved_code[NW-1:0]};
        end
        default: next_state.rdata = seq_out_pkg::READ_DATA_RESET;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pin_out       = state.pin_out;
  assign pin_oe        = state.pin_oe;
  assign track_en      = state.track_en;
  assign pump_en       = state.pump_en;
  assign reserved_code = state.reserved_code;
  assign cfg_rdata     = state.rdata;
  assign cfg_rvalid    = state.rvalid;

endmodule

// [rtl/seq_out_pkg.sv]
package seq_out_pkg;

  // ****************************************************************
  // register offsets and reset values
  // ****************************************************************
  localparam logic [7:0] OUTPUT_CONFIG_A_OFFSET = 8'h1F;
  localparam logic [7:0] OUTPUT_CONFIG_B_OFFSET = 8'h20;
  localparam logic [7:0] OUTPUT_CONFIG_C_OFFSET = 8'h21;
  localparam logic [7:0] OUTPUT_STATUS_OFFSET   = 8'h23;
  localparam logic [7:0] OUTPUT_CONFIG_RESET    = 8'h00;
  localparam logic [7:0] READ_DATA_RESET        = 8'h00;

  // ****************************************************************
  // counts of outputs
  // ****************************************************************
  localparam int NUM_OUTPUTS      = 9;
  localparam int NUM_WIDE_OUTPUTS = 6;
  localparam int NUM_TRACK_OUTPUTS = 4;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int OUT1_LSB    = 0;
  localparam int OUT2_LSB    = 3;
  localparam int OUT3_LO_LSB = 6;
  localparam int OUT3_HI_BIT = 0;
  localparam int OUT4_LSB    = 1;
  localparam int OUT5_LSB    = 4;
  localparam int OUT6_LO_BIT = 7;
  localparam int OUT6_HI_LSB = 0;
  localparam int OUT7_LSB    = 2;
  localparam int OUT8_LSB    = 4;
  localparam int OUT9_LSB    = 6;

  // ****************************************************************
  // status register bit positions
  // ****************************************************************
  localparam int STATUS_TRACK_BIT = 6;
  localparam int STATUS_PUMP_BIT  = 7;

  // charge-pump gate target above the matching monitor_input, in mV
  localparam int PUMP_OFFSET_MV = 5000;

  // ****************************************************************
  // drive codes
  // ****************************************************************
  typedef enum logic [2:0] {
    CODE_OD_LOW  = 3'h0,
    CODE_OD_HIGH = 3'h1,
    CODE_PP_LOW  = 3'h2,
    CODE_PP_HIGH = 3'h3,
    CODE_TRACK   = 3'h4,
    CODE_PUMP    = 3'h5,
    CODE_RSVD_6  = 3'h6,
    CODE_RSVD_7  = 3'h7
  } drive_code_t;

endpackage

// [rtl/output_drive_decode.sv]
module output_drive_decode (
  // configuration
  input  wire logic [2:0] code,
  input  wire logic       has_track,
  input  wire logic       has_pump,
  // sequencer request
  input  wire logic       assert_req,
  // decoded drive
  output logic            drive_level,
  output logic            drive_oe,
  output logic            track_sel,
  output logic            pump_sel,
  output logic            reserved_hit
);

  seq_out_pkg::drive_code_t sel;

  always_comb begin
    sel          = seq_out_pkg::drive_code_t'(code);
    drive_level  = 1'b0;
    drive_oe     = 1'b0;
    track_sel    = 1'b0;
    pump_sel     = 1'b0;
    reserved_hit = 1'b0;
    unique case (sel)
      // open-drain: pull low only for the low level, else release
      seq_out_pkg::CODE_OD_LOW: begin
        drive_oe = assert_req;
      end
      seq_out_pkg::CODE_OD_HIGH: begin
        drive_oe = ~assert_req;
      end
      seq_out_pkg::CODE_PP_LOW: begin
        drive_oe    = 1'b1;
        drive_level = ~assert_req;
      end
      seq_out_pkg::CODE_PP_HIGH: begin
        drive_oe    = 1'b1;
        drive_level = assert_req;
      end
      seq_out_pkg::CODE_TRACK: begin
        // output without tracking falls back to released pin
        track_sel    = has_track;
        reserved_hit = ~has_track;
      end
      seq_out_pkg::CODE_PUMP: begin
        pump_sel     = has_pump & assert_req;
        reserved_hit = ~has_pump;
      end
      seq_out_pkg::CODE_RSVD_6,
      seq_out_pkg::CODE_RSVD_7: begin
        reserved_hit = 1'b1;
      end
    endcase
  end

endmodule

// [rtl/output_config_regs.sv]
module output_config_regs (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // write port
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  input  wire logic       cfg_wr,
  // stored configuration
  output logic      [7:0] config_a,
  output logic      [7:0] config_b,
  output logic      [7:0] config_c
);

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
  } regs_t;

  regs_t state;
  regs_t next_state;

  always_comb begin
    next_state = state;
    if (cfg_wr) begin
      unique case (cfg_addr)
        seq_out_pkg::OUTPUT_CONFIG_A_OFFSET: next_state.a = cfg_wdata;
        seq_out_pkg::OUTPUT_CONFIG_B_OFFSET: next_state.b = cfg_wdata;
        seq_out_pkg::OUTPUT_CONFIG_C_OFFSET: next_state.c = cfg_wdata;
        default:                             next_state   = state;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= {3{seq_out_pkg::OUTPUT_CONFIG_RESET}};
    end else begin
      state <= next_state;
    end
  end

  assign config_a = state.a;
  assign config_b = state.b;
  assign config_c = state.c;

endmodule

// [bench/seq_decode_asserts.sv]
module seq_decode_asserts (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  // register port
  input wire logic       cfg_wr,
  input wire logic       cfg_rd,
  input wire logic [7:0] cfg_rdata,
  input wire logic       cfg_rvalid,
  // requests and drive
  input wire logic [8:0] assert_req,
  input wire logic [8:0] pin_out,
  input wire logic [8:0] pin_oe,
  input wire logic [3:0] track_en,
  input wire logic [5:0] pump_en,
  input wire logic [8:0] reserved_code
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  rvalid_after_read_a: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read strobe not answered");
  rvalid_has_cause_a: assert property (cfg_rvalid |-> $past(cfg_rd))
    else $error("read valid without a read");
  rdata_holds_a: assert property ($changed(cfg_rdata) |-> cfg_rvalid)
    else $error("read data moved between reads");
  pump_follows_req_a: assert property (
    (pump_en & ~$past(assert_req[5:0])) == 6'h00)
    else $error("pump on without request");
  mode_pin_released_a: assert property (
    (({2'h0, track_en} | pump_en | reserved_code[5:0]) & pin_oe[5:0])
    == 6'h00) else $error("pin driven in analog or reserved mode");
  out_needs_oe_a: assert property ((pin_out & ~pin_oe) == 9'h000)
    else $error("pin level high while released");
  narrow_no_rsvd_a: assert property (reserved_code[8:6] == 3'h0)
    else $error("two-bit output flagged reserved");
  // a write lands one edge after its strobe and reaches the pins one
  // edge later, a request reaches the pins one edge after it is taken
  drive_steady_a: assert property (
    !$past(sys_rst, 2) && !$past(cfg_wr, 2) &&
    ($past(assert_req) == $past(assert_req, 2)) |->
    $stable({pin_out, pin_oe, track_en, pump_en, reserved_code}))
    else $error("drive changed without cause");
endmodule

// [bench/sequencer_output_config_decode_tb_top.sv]
module sequencer_output_config_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk, sys_rst, cfg_wr, cfg_rd, cfg_rvalid;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
  logic [8:0] assert_req, pin_out, pin_oe, reserved_code;
  logic [3:0] track_en;
  logic [5:0] pump_en;
  int         failures = 0;
  int         n_checks = 0;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end

  sequencer_output_config_decode u_sequencer_output_config_decode (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .assert_req(assert_req),
    .pin_out(pin_out), .pin_oe(pin_oe), .track_en(track_en),
    .pump_en(pump_en), .reserved_code(reserved_code));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // bus tasks and drive model
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge ref_clk);
    `CHK(cfg_rvalid, 1'b1)
    `CHK(cfg_rdata, e)
  endtask

  // returns {reserved, pump, track, oe, out}
  function automatic logic [4:0] model(logic [2:0] c, logic r, int i);
    case (c)
      3'h0: return {3'h0, r, 1'b0};
      3'h1: return {3'h0, ~r, 1'b0};
      3'h2: return {3'h0, 1'b1, ~r};
      3'h3: return {3'h0, 1'b1, r};
      3'h4: return (i < 4) ? 5'h04 : 5'h10;
      3'h5: return {1'b0, r, 3'h0};
      default: return 5'h10;
    endcase
  endfunction

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(seq_out_pkg::OUTPUT_CONFIG_A_OFFSET, 8'h00);
    rd(seq_out_pkg::OUTPUT_CONFIG_B_OFFSET, 8'h00);
    rd(seq_out_pkg::OUTPUT_CONFIG_C_OFFSET, 8'h00);
    cfg_rd = 1'b0;
    `CHK(pin_oe, 9'h000)
    $display("reset test done");
  endtask

  task automatic t_decode();
    logic [23:0] w;
    logic [8:0]  req, eo, eoe, er;
    logic [3:0]  et;
    logic [5:0]  ep;
    logic [4:0]  m;
    logic [2:0]  c;
    for (int k = 0; k < 8; k++) begin
      for (int j = 0; j < 3; j++) begin
        req = (j == 0) ? 9'h000 : (j == 1) ? 9'h1ff : 9'h155;
        w = 24'h00_0000;
        // outputs 1-6 get different codes and outputs 7-9 differ among themselves, so misplaced fields show
        for (int i = 0; i < 6; i++) w[3*i +: 3] = 3'(k + i);
        for (int i = 6; i < 9; i++) w[2*i + 6 +: 2] = 2'(k + i);
        wr(seq_out_pkg::OUTPUT_CONFIG_A_OFFSET, w[7:0]);
        wr(seq_out_pkg::OUTPUT_CONFIG_B_OFFSET, w[15:8]);
        wr(seq_out_pkg::OUTPUT_CONFIG_C_OFFSET, w[23:16]);
        cfg_wr = 1'b0;
        assert_req = req;
        @(negedge ref_clk);
        for (int i = 0; i < 9; i++) begin
          c = (i < 6) ? w[3*i +: 3] : {1'b0, w[2*i + 6 +: 2]};
          m = model(c, req[i], i);
          {er[i], eoe[i], eo[i]} = {m[4], m[1], m[0]};
          if (i < 4) et[i] = m[2];
          if (i < 6) ep[i] = m[3];
        end
        `CHK(pin_out, eo)
        `CHK(pin_oe, eoe)
        `CHK(track_en, et)
        `CHK(pump_en, ep)
        `CHK(reserved_code, er)
      end
    end
    $display("decode test done");
  endtask

  task automatic t_regs();
    wr(seq_out_pkg::OUTPUT_CONFIG_A_OFFSET, 8'h12);
    wr(seq_out_pkg::OUTPUT_CONFIG_B_OFFSET, 8'h34);
    wr(seq_out_pkg::OUTPUT_CONFIG_C_OFFSET, 8'h56);
    wr(8'h22, 8'hff);
    cfg_wr = 1'b0;
    rd(seq_out_pkg::OUTPUT_CONFIG_A_OFFSET, 8'h12);
    rd(seq_out_pkg::OUTPUT_CONFIG_B_OFFSET, 8'h34);
    rd(seq_out_pkg::OUTPUT_CONFIG_C_OFFSET, 8'h56);
    rd(8'h22, 8'h00);
    cfg_rd = 1'b0;
    @(negedge ref_clk);
    `CHK(cfg_rvalid, 1'b0)
    `CHK(cfg_rdata, 8'h00)
    // output 6 holds the tracking code it lacks: reserved in status
    rd(seq_out_pkg::OUTPUT_STATUS_OFFSET, 8'h20);
    cfg_rd = 1'b0;
    assert_req = 9'h1ff;
    // output 1 tracking, output 2 charge pump
    wr(seq_out_pkg::OUTPUT_CONFIG_A_OFFSET, 8'h2c);
    cfg_wr = 1'b0;
    @(negedge ref_clk);
    `CHK(track_en, 4'h1)
    `CHK(pump_en, 6'h02)
    rd(seq_out_pkg::OUTPUT_STATUS_OFFSET, 8'he0);
    cfg_rd = 1'b0;
    $display("register test done");
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #20us;
    failures++;
    conclude();
  end

  initial begin
    {sys_rst, cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {3'h4, 16'h0000};
    assert_req = 9'h000;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    t_reset();
    t_decode();
    t_regs();
    conclude();
  end
endmodule

bind sequencer_output_config_decode seq_decode_asserts u_seq_decode_asserts (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
  .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .assert_req(assert_req),
  .pin_out(pin_out), .pin_oe(pin_oe), .track_en(track_en),
  .pump_en(pump_en), .reserved_code(reserved_code));
